/* File: include/iopa_pkg.sv */
// Constants, opcodes and register map of the accumulator execution block
package iopa_pkg;
    // Instruction parcel layout
    localparam int PARCEL_W = 16;
    localparam int DISP_W = 9;
    localparam int FUNC_W = 7;
    localparam int FUNC_LSB = 9;
    localparam int ACC_W = 16;
    localparam int CNT_W = 5;

    // Function codes handled here
    localparam logic [6:0] OP_PASS = 7'h00;
    localparam logic [6:0] OP_EXIT = 7'h01;
    localparam logic [6:0] OP_IEN0 = 7'h02;
    localparam logic [6:0] OP_IEN1 = 7'h03;
    localparam logic [6:0] OP_LSR = 7'h04;
    localparam logic [6:0] OP_LSL = 7'h05;
    localparam logic [6:0] OP_CSR = 7'h06;
    localparam logic [6:0] OP_CSL = 7'h07;
    localparam logic [6:0] OP_LDD = 7'h08;
    localparam logic [6:0] OP_ANDD = 7'h09;
    localparam logic [6:0] OP_ADDD = 7'h0a;
    localparam logic [6:0] OP_SUBD = 7'h0b;
    localparam logic [6:0] OP_LDK = 7'h0c;
    localparam logic [6:0] OP_ANDK = 7'h0d;
    localparam logic [6:0] OP_ADDK = 7'h0e;
    localparam logic [6:0] OP_SUBK = 7'h0f;

    // Branch and I/O codes that do not arm the system enable
    localparam logic [6:0] BRIO_A_LO = 7'h20;
    localparam logic [6:0] BRIO_A_HI = 7'h23;
    localparam logic [6:0] BRIO_B_LO = 7'h38;
    localparam logic [6:0] BRIO_B_HI = 7'h5f;

    // Shift limits
    localparam logic [4:0] LSR_MAX = 5'h10;
    localparam logic [4:0] LSL_MAX = 5'h11;
    localparam logic [4:0] ROT_LEN = 5'h11;

    // Least gap between a stack change and a return, in CPs
    localparam int EXIT_GAP_CP = 4;

    // Register byte offsets
    localparam logic [7:0] ADDR_PARCEL = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_PADDR = 8'h08;
    localparam logic [7:0] ADDR_ESP = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [1:0] ESTK_PAGE = 2'h1;

    // Field positions
    localparam int ACC_CARRY_BIT = 16;
    localparam int FLG_SIE = 0;
    localparam int FLG_DLY = 1;
    localparam int FLG_BOUND = 2;
    localparam int FLG_BUSY = 3;
    localparam int FLG_WAITK = 4;

    // Reset values
    localparam logic [15:0] ACC_RST = 16'h0000;
    localparam logic [15:0] P_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_K,
        ST_EXEC1,
        ST_EXEC2
    } iopa_state_type;
endpackage : iopa_pkg

/* File: hdl/iopa_core.sv */
// Accumulator, exit stack and interrupt enable execution with AHB-Lite regs
`timescale 1ns/1ps
module iopa_core #(
    parameter int ESTK_DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Processor state
    output logic sys_int_en,
    output logic exit_bound
);
    localparam int EW = $clog2(ESTK_DEPTH);

    generate
        if (ESTK_DEPTH < 2 || ESTK_DEPTH > 16 ||
            (1 << EW) != ESTK_DEPTH) begin : g_bad_depth
            $error("ESTK_DEPTH must be a power of two from 2 to 16");
        end
    endgenerate

    iopa_pkg::iopa_state_type state_q;
    logic [6:0] op_q;
    logic [15:0] acc_q;
    logic carry_q;
    logic [15:0] addend_q;
    logic [16:0] res_q;
    logic [15:0] p_q;
    logic [EW-1:0] e_q;
    logic [15:0] estk_q [ESTK_DEPTH];
    logic sie_q;
    logic dly_q;
    logic bound_q;
    logic dph_q;
    logic dwrite_q;
    logic dmap_q;
    logic [7:0] daddr_q;
    logic rdy_q;
    logic [31:0] rdata_q;
    logic resp_q;

    // Branch and I/O codes never activate a pending enable
    function automatic logic is_brio(input logic [6:0] f);
        return (f >= iopa_pkg::BRIO_A_LO && f <= iopa_pkg::BRIO_A_HI) ||
               (f >= iopa_pkg::BRIO_B_LO && f <= iopa_pkg::BRIO_B_HI);
    endfunction : is_brio

    function automatic logic is_shift(input logic [6:0] f);
        return f == iopa_pkg::OP_LSR || f == iopa_pkg::OP_LSL ||
               f == iopa_pkg::OP_CSR || f == iopa_pkg::OP_CSL;
    endfunction : is_shift

    function automatic logic is_kop(input logic [6:0] f);
        return f == iopa_pkg::OP_LDK || f == iopa_pkg::OP_ANDK ||
               f == iopa_pkg::OP_ADDK || f == iopa_pkg::OP_SUBK;
    endfunction : is_kop

    // Bus address phase and data phase bookkeeping
    logic aphase;
    logic busy;
    logic ok;
    logic wr_go;
    logic in_estk;
    logic [EW-1:0] eidx;
    logic parcel_wr;
    logic issue;
    logic kwr;
    logic [6:0] f;
    logic [15:0] dz;
    logic [15:0] kval;
    logic [15:0] exit_tgt;

    assign aphase = hsel && htrans[1] && hready;
    assign busy = state_q == iopa_pkg::ST_EXEC1 ||
                  state_q == iopa_pkg::ST_EXEC2;
    // Parcel and accumulator writes stall while the datapath is busy
    assign ok = !(busy && dwrite_q && dmap_q &&
                  (daddr_q == iopa_pkg::ADDR_PARCEL ||
                   daddr_q == iopa_pkg::ADDR_ACC));
    assign wr_go = dph_q && dwrite_q && dmap_q && ok;
    assign in_estk = daddr_q[7:6] == iopa_pkg::ESTK_PAGE &&
                     {1'b0, daddr_q[5:2]} < 5'(ESTK_DEPTH);
    assign eidx = daddr_q[EW+1:2];
    assign parcel_wr = wr_go && daddr_q == iopa_pkg::ADDR_PARCEL;
    assign issue = parcel_wr && state_q == iopa_pkg::ST_IDLE;
    assign kwr = parcel_wr && state_q == iopa_pkg::ST_WAIT_K;
    assign f = hwdata[iopa_pkg::FUNC_LSB +: iopa_pkg::FUNC_W];
    assign dz = {7'h00, hwdata[iopa_pkg::DISP_W-1:0]};
    assign kval = hwdata[iopa_pkg::PARCEL_W-1:0];
    assign exit_tgt = estk_q[e_q];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dph_q <= 1'b0;
            dwrite_q <= 1'b0;
            dmap_q <= 1'b0;
            daddr_q <= 8'h00;
        end else if (aphase) begin
            dph_q <= 1'b1;
            dwrite_q <= hwrite;
            dmap_q <= haddr[31:8] == 24'h00_0000;
            daddr_q <= haddr[7:0];
        end else if (dph_q && ok) begin
            dph_q <= 1'b0;
        end
    end

    // One wait state per transfer, more while a write stalls, keeps hreadyout a flop
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdy_q <= 1'b1;
        end else if (aphase) begin
            rdy_q <= 1'b0;
        end else if (dph_q && ok) begin
            rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= iopa_pkg::RDATA_RST;
        end else if (dph_q && !dwrite_q && dmap_q) begin
            if (daddr_q == iopa_pkg::ADDR_ACC) begin
                rdata_q <= {15'h0000, carry_q, acc_q};
            end else if (daddr_q == iopa_pkg::ADDR_PADDR) begin
                rdata_q <= {16'h0000, p_q};
            end else if (daddr_q == iopa_pkg::ADDR_ESP) begin
                rdata_q <= {{(32-EW){1'b0}}, e_q};
            end else if (daddr_q == iopa_pkg::ADDR_FLAGS) begin
                rdata_q <= {27'h000_0000,
                            state_q == iopa_pkg::ST_WAIT_K,
                            busy, bound_q, dly_q, sie_q};
            end else if (in_estk) begin
                rdata_q <= {16'h0000, estk_q[eidx]};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else if (dph_q) begin
            rdata_q <= 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        resp_q <= 1'b0;
    end

    // Sequencer: issue, optional constant parcel, then two datapath cycles for shifts, adds and subtracts
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= iopa_pkg::ST_IDLE;
            op_q <= iopa_pkg::OP_PASS;
        end else begin
            case (state_q)
                iopa_pkg::ST_IDLE: begin
                    if (issue) begin
                        op_q <= f;
                        if (is_shift(f) || f == iopa_pkg::OP_ADDD ||
                            f == iopa_pkg::OP_SUBD) begin
                            state_q <= iopa_pkg::ST_EXEC1;
                        end else if (is_kop(f)) begin
                            state_q <= iopa_pkg::ST_WAIT_K;
                        end
                    end
                end
                iopa_pkg::ST_WAIT_K: begin
                    if (kwr) begin
                        if (op_q == iopa_pkg::OP_ADDK ||
                            op_q == iopa_pkg::OP_SUBK) begin
                            state_q <= iopa_pkg::ST_EXEC1;
                        end else begin
                            state_q <= iopa_pkg::ST_IDLE;
                        end
                    end
                end
                iopa_pkg::ST_EXEC1: state_q <= iopa_pkg::ST_EXEC2;
                iopa_pkg::ST_EXEC2: state_q <= iopa_pkg::ST_IDLE;
                default: state_q <= iopa_pkg::ST_IDLE;
            endcase
        end
    end

    // Addend register; free once the operands reach the shifter or adder
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addend_q <= 16'h0000;
        end else if (issue && (is_shift(f) || f == iopa_pkg::OP_ADDD ||
                               f == iopa_pkg::OP_SUBD)) begin
            addend_q <= dz;
        end else if (kwr) begin
            addend_q <= kval;
        end
    end

    // Shifter over the seventeen bit carry and accumulator
    logic [4:0] cnt;
    logic [4:0] rot;
    logic [16:0] cval;
    logic [33:0] dbl;
    logic [16:0] shift_res;

    assign cnt = addend_q[iopa_pkg::CNT_W-1:0];
    assign rot = cnt >= iopa_pkg::ROT_LEN ? cnt - iopa_pkg::ROT_LEN : cnt;
    assign cval = {carry_q, acc_q};
    assign dbl = {cval, cval};

    always_comb begin
        shift_res = cval;
        case (op_q)
            iopa_pkg::OP_LSR: begin
                shift_res = cnt > iopa_pkg::LSR_MAX ? 17'h0_0000
                                                    : cval >> cnt;
            end
            iopa_pkg::OP_LSL: begin
                shift_res = cnt > iopa_pkg::LSL_MAX ? 17'h0_0000
                                                    : cval << cnt;
            end
            iopa_pkg::OP_CSR: shift_res = 17'(dbl >> rot);
            iopa_pkg::OP_CSL: shift_res = dbl[33:17] << rot |
                                          17'(cval >> (5'd17 - rot));
            default: shift_res = cval;
        endcase
    end

    // Adder; subtract complements the addend, then adds one
    logic sub;
    logic [16:0] sum1;
    logic [16:0] sum2;
    logic [16:0] add_res;

    assign sub = op_q == iopa_pkg::OP_SUBD || op_q == iopa_pkg::OP_SUBK;
    assign sum1 = {1'b0, acc_q} + {1'b0, sub ? ~addend_q : addend_q};
    assign sum2 = {1'b0, sum1[15:0]} + {16'h0000, sub};
    // Carry flips once if either stage carries out
    assign add_res = {carry_q ^ (sum1[16] | sum2[16]),
                      sum2[15:0]};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            res_q <= 17'h0_0000;
        end else if (state_q == iopa_pkg::ST_EXEC1) begin
            res_q <= is_shift(op_q) ? shift_res : add_res;
        end
    end

    // Accumulator and carry
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acc_q <= iopa_pkg::ACC_RST;
            carry_q <= 1'b0;
        end else if (wr_go && daddr_q == iopa_pkg::ADDR_ACC) begin
            acc_q <= hwdata[15:0];
            carry_q <= hwdata[iopa_pkg::ACC_CARRY_BIT];
        end else if (issue && f == iopa_pkg::OP_LDD) begin
            acc_q <= dz;
            carry_q <= 1'b0;
        end else if (issue && f == iopa_pkg::OP_ANDD) begin
            acc_q <= acc_q & dz;
            carry_q <= 1'b0;
        end else if (kwr && op_q == iopa_pkg::OP_LDK) begin
            acc_q <= kval;
            carry_q <= 1'b0;
        end else if (kwr && op_q == iopa_pkg::OP_ANDK) begin
            acc_q <= acc_q & kval;
            carry_q <= 1'b0;
        end else if (state_q == iopa_pkg::ST_EXEC2) begin
            acc_q <= res_q[15:0];
            carry_q <= res_q[16];
        end
    end

    // Program address: advances per parcel, reloaded on return
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            p_q <= iopa_pkg::P_RST;
        end else if (wr_go && daddr_q == iopa_pkg::ADDR_PADDR) begin
            p_q <= hwdata[15:0];
        end else if (issue && f == iopa_pkg::OP_EXIT) begin
            p_q <= exit_tgt;
        end else if (issue || kwr) begin
            p_q <= p_q + 16'h0001;
        end
    end

    // Exit stack pointer; software must allow the settling gap itself
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            e_q <= '0;
        end else if (wr_go && daddr_q == iopa_pkg::ADDR_ESP) begin
            e_q <= hwdata[EW-1:0];
        end else if (issue && f == iopa_pkg::OP_EXIT && e_q != '0) begin
            e_q <= e_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_go && in_estk) begin
            estk_q[eidx] <= hwdata[15:0];
        end
    end

    // Boundary flag: a new underflow wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bound_q <= 1'b0;
        end else if (issue && f == iopa_pkg::OP_EXIT && e_q == '0) begin
            bound_q <= 1'b1;
        end else if (wr_go && daddr_q == iopa_pkg::ADDR_FLAGS &&
                     hwdata[iopa_pkg::FLG_BOUND]) begin
            bound_q <= 1'b0;
        end
    end

    // System interrupt enable with delayed arming
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sie_q <= 1'b0;
            dly_q <= 1'b0;
        end else if (issue) begin
            if (f == iopa_pkg::OP_IEN0) begin
                sie_q <= 1'b0;
                dly_q <= 1'b0;
            end else if (f == iopa_pkg::OP_IEN1) begin
                dly_q <= 1'b1;
            end else if (dly_q && !is_brio(f)) begin
                sie_q <= 1'b1;
                dly_q <= 1'b0;
            end
        end
    end

    assign hreadyout = rdy_q;
    assign hrdata = rdata_q;
    assign hresp = resp_q;
    assign sys_int_en = sie_q;
    assign exit_bound = bound_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_two_step;
        state_q == iopa_pkg::ST_EXEC1 ##1 state_q == iopa_pkg::ST_EXEC2
            ##1 state_q == iopa_pkg::ST_IDLE;
    endsequence

    // Issues sit at least two cycles apart, so five can span two more issues
    sequence s_en_then_dis;
        issue && f == iopa_pkg::OP_IEN1 ##[1:5]
            issue && f == iopa_pkg::OP_IEN0;
    endsequence

    // A pending enable may legally take effect on a no-op
    a_pass_no_change: assert property (
        issue && f == iopa_pkg::OP_PASS && !dly_q |=> $stable(acc_q) &&
            $stable(carry_q) && $stable(e_q) && $stable(sie_q) &&
            state_q == iopa_pkg::ST_IDLE)
        else $error("no-op changed state or took more than one cycle");

    a_exit_load: assert property (
        issue && f == iopa_pkg::OP_EXIT && e_q != '0 |=>
            p_q == $past(exit_tgt) && e_q == $past(e_q) - 1'b1)
        else $error("return did not load address or decrement pointer");

    a_exit_bound: assert property (
        issue && f == iopa_pkg::OP_EXIT && e_q == '0 |=>
            bound_q && e_q == '0)
        else $error("return at pointer zero mishandled");

    a_dis_wins: assert property (
        s_en_then_dis |=> !sie_q && !dly_q)
        else $error("disable after enable did not win");

    a_ien_delay: assert property (
        issue && f == iopa_pkg::OP_IEN1 && !sie_q |=> !sie_q && dly_q)
        else $error("enable took effect without delay");

    a_ien_take: assert property (
        issue && dly_q && !is_brio(f) && f != iopa_pkg::OP_IEN0 &&
            f != iopa_pkg::OP_IEN1 |=> sie_q)
        else $error("pending enable not activated");

    a_idis_clear: assert property (
        issue && f == iopa_pkg::OP_IEN0 |=> !sie_q)
        else $error("disable did not clear system enable");

    a_shift_timing: assert property (
        issue && is_shift(f) |=> s_two_step)
        else $error("shift timing wrong");

    a_add_timing: assert property (
        issue && (f == iopa_pkg::OP_ADDD || f == iopa_pkg::OP_SUBD)
            |=> s_two_step)
        else $error("immediate add or subtract timing wrong");

    a_load_d: assert property (
        issue && f == iopa_pkg::OP_LDD |=> acc_q == $past(dz) && !carry_q)
        else $error("immediate load result wrong");

    a_lsr_clear: assert property (
        state_q == iopa_pkg::ST_EXEC1 && op_q == iopa_pkg::OP_LSR &&
            cnt > iopa_pkg::LSR_MAX |=> ##1 acc_q == 16'h0000 && !carry_q)
        else $error("long right shift did not clear");

    a_shift_zero: assert property (
        state_q == iopa_pkg::ST_EXEC1 && is_shift(op_q) && cnt == 5'h00
            |-> shift_res == cval)
        else $error("zero count shift changed value");
endmodule : iopa_core

/* File: verification/iopa_fetch.sv */
// Program parcel store standing in for the instruction fetch side
`timescale 1ns/1ps
module iopa_fetch (
    // Clock
    input wire logic sys_clk,
    // Program load
    input wire logic prog_we,
    input wire logic [3:0] prog_idx,
    input wire logic [15:0] prog_val,
    // Fetch
    input wire logic [3:0] pc,
    output logic [15:0] parcel
);
    logic [15:0] mem_q [16];

    always_ff @(posedge sys_clk) begin
        if (prog_we) begin
            mem_q[prog_idx] <= prog_val;
        end
    end

    // Constant sits in the slot right after its instruction
    assign parcel = mem_q[pc];
endmodule : iopa_fetch

/* File: verification/tb_io_processor_accumulator_ops.sv */
// Self-checking bench for the accumulator execution block
`timescale 1ns/1ps
module tb_io_processor_accumulator_ops;
    logic sys_clk = 1'b0;
    logic sys_rst, hsel, hwrite, prog_we;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic hreadyout, hresp, sys_int_en, exit_bound;
    logic [3:0] prog_idx, pc;
    logic [15:0] prog_val, parcel, v, p;
    logic [16:0] e;
    logic [6:0] o;
    logic [4:0] cnts [7] = '{5'h00, 5'h01, 5'h05, 5'h10, 5'h11, 5'h12, 5'h1f};
    logic [6:0] brio [4] = '{7'h20, 7'h23, 7'h38, 7'h5f};
    int err_total = 0;
    int total_checks = 0;
    int seed = 32;
    int cyc_cnt = 0;

    iopa_core #(.ESTK_DEPTH(16)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .sys_int_en(sys_int_en),
        .exit_bound(exit_bound)
    );

    iopa_fetch fetch_u (
        .sys_clk(sys_clk), .prog_we(prog_we), .prog_idx(prog_idx),
        .prog_val(prog_val), .pc(pc), .parcel(parcel)
    );

    always #20 sys_clk = ~sys_clk;

    // Carry is bit 16 of the 17-bit value
    function automatic logic [16:0] exp_acc(input logic [6:0] op,
            input logic [15:0] val, input logic [16:0] a);
        logic [33:0] w;
        logic [16:0] s, t, u;
        int n;
        n = int'(val[4:0]);
        s = {1'b0, a[15:0]} + {1'b0, val};
        t = {1'b0, a[15:0]} + {1'b0, ~val};
        u = {1'b0, t[15:0]} + 17'h00001;
        case (op)
            7'h04: return (n > 16) ? 17'h0 : a >> n;
            7'h05: return (n > 17) ? 17'h0 : a << n;
            7'h06: w = {a, a} >> (n % 17);
            7'h07: w = {a, a} >> ((17 - n % 17) % 17);
            default: begin
                case (op[1:0])
                    2'h0: return {1'b0, val};
                    2'h1: return {1'b0, a[15:0] & val};
                    2'h2: return {a[16] ^ s[16], s[15:0]};
                    default: return {a[16] ^ (t[16] | u[16]), u[15:0]};
                endcase
            end
        endcase
        return w[16:0];
    endfunction : exp_acc

    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Entered right after a rising edge; holds each phase until ready
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic rdc(input string nm, input logic [7:0] a,
            input logic [31:0] exp);
        logic [31:0] rv;
        bus(1'b0, a, 32'h0, rv);
        chk(nm, rv, exp);
    endtask : rdc

    task automatic par(input logic [6:0] op, input logic [8:0] d);
        logic [31:0] rv;
        bus(1'b1, iopa_pkg::ADDR_PARCEL, {16'h0, op, d}, rv);
    endtask : par

    // Two-parcel op: fetch side hands over instruction then constant
    task automatic feed2(input logic [15:0] p0, input logic [15:0] p1);
        logic [31:0] rv;
        prog_we <= 1'b1;
        prog_idx <= 4'h0;
        prog_val <= p0;
        @(posedge sys_clk);
        prog_idx <= 4'h1;
        prog_val <= p1;
        @(posedge sys_clk);
        prog_we <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            pc <= 4'(i);
            @(posedge sys_clk);
            bus(1'b1, iopa_pkg::ADDR_PARCEL, {16'h0, parcel}, rv);
        end
    endtask : feed2

    task automatic do_op(input logic [6:0] op, input logic [15:0] val,
            input logic [16:0] acc);
        logic [31:0] rv;
        bus(1'b1, iopa_pkg::ADDR_ACC, {15'h0, acc}, rv);
        if (op >= 7'h0c) begin
            feed2({op, 9'h000}, val);
        end else begin
            par(op, val[8:0]);
        end
        repeat (3) @(posedge sys_clk);
        e = exp_acc(op, val, acc);
        rdc("acc", iopa_pkg::ADDR_ACC, {15'h0, e});
    endtask : do_op

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 8000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        prog_we = 1'b0;
        prog_idx = 4'h0;
        prog_val = 16'h0;
        pc = 4'h0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdc("acc", iopa_pkg::ADDR_ACC, 32'h0);
        chk("sie", {31'h0, sys_int_en}, 32'h0);
        chk("bound", {31'h0, exit_bound}, 32'h0);
        bus(1'b1, 8'h3c, 32'hffff_ffff, r);
        rdc("hole", 8'h3c, 32'h0);
        bus(1'b1, iopa_pkg::ADDR_ACC, 32'h0001_a5a5, r);
        bus(1'b0, iopa_pkg::ADDR_PADDR, 32'h0, r);
        p = r[15:0] + 16'h0001;
        par(iopa_pkg::OP_PASS, 9'h1ff);
        rdc("flags", iopa_pkg::ADDR_FLAGS, 32'h0);
        rdc("acc", iopa_pkg::ADDR_ACC, 32'h0001_a5a5);
        rdc("paddr", iopa_pkg::ADDR_PADDR, {16'h0, p});
        for (int m = 4; m < 8; m++) begin
            foreach (cnts[j]) begin
                v = 16'($random(seed));
                e = 17'($random(seed));
                v = {7'h0, v[15:12], cnts[j]};
                do_op(7'(m), v, e);
            end
        end
        repeat (32) begin
            o = 7'h08 + 7'($random(seed) & 7);
            v = 16'($random(seed));
            if (o < 7'h0c) v[15:9] = 7'h0;
            e = 17'($random(seed));
            do_op(o, v, e);
        end
        do_op(iopa_pkg::OP_SUBD, 16'h0, 17'h0);
        do_op(iopa_pkg::OP_ADDK, 16'hffff, 17'h10001);
        bus(1'b1, iopa_pkg::ADDR_ACC, 32'h0001_fff0, r);
        par(iopa_pkg::OP_ADDD, 9'h00f);
        par(iopa_pkg::OP_SUBD, 9'h1ff);
        repeat (3) @(posedge sys_clk);
        e = exp_acc(iopa_pkg::OP_ADDD, 16'h000f, 17'h1fff0);
        e = exp_acc(iopa_pkg::OP_SUBD, 16'h01ff, e);
        rdc("acc", iopa_pkg::ADDR_ACC, {15'h0, e});
        v = 16'($random(seed));
        bus(1'b1, 8'h4c, {16'h0, v}, r);
        bus(1'b1, iopa_pkg::ADDR_ESP, 32'h3, r);
        // Software gap before a return
        repeat (4) @(posedge sys_clk);
        par(iopa_pkg::OP_EXIT, 9'h0);
        rdc("paddr", iopa_pkg::ADDR_PADDR, {16'h0, v});
        rdc("esp", iopa_pkg::ADDR_ESP, 32'h2);
        chk("bound", {31'h0, exit_bound}, 32'h0);
        bus(1'b1, iopa_pkg::ADDR_ESP, 32'h0, r);
        repeat (4) @(posedge sys_clk);
        par(iopa_pkg::OP_EXIT, 9'h0);
        chk("bound", {31'h0, exit_bound}, 32'h1);
        rdc("esp", iopa_pkg::ADDR_ESP, 32'h0);
        bus(1'b1, iopa_pkg::ADDR_FLAGS, 32'h4, r);
        chk("bound", {31'h0, exit_bound}, 32'h0);
        par(iopa_pkg::OP_IEN1, 9'h0);
        chk("sie", {31'h0, sys_int_en}, 32'h0);
        rdc("flags", iopa_pkg::ADDR_FLAGS, 32'h2);
        par(iopa_pkg::OP_PASS, 9'h0);
        chk("sie", {31'h0, sys_int_en}, 32'h1);
        par(iopa_pkg::OP_IEN0, 9'h0);
        chk("sie", {31'h0, sys_int_en}, 32'h0);
        foreach (brio[i]) begin
            par(iopa_pkg::OP_IEN1, 9'h0);
            par(brio[i], 9'h0);
            chk("sie", {31'h0, sys_int_en}, 32'h0);
        end
        par(iopa_pkg::OP_LDD, 9'h0);
        chk("sie", {31'h0, sys_int_en}, 32'h1);
        par(iopa_pkg::OP_IEN0, 9'h0);
        par(iopa_pkg::OP_IEN1, 9'h0);
        par(iopa_pkg::OP_IEN0, 9'h0);
        chk("sie", {31'h0, sys_int_en}, 32'h0);
        par(iopa_pkg::OP_PASS, 9'h0);
        chk("sie", {31'h0, sys_int_en}, 32'h0);
        complete_run();
    end
endmodule : tb_io_processor_accumulator_ops
